/* File: flash_pin_pkg.sv */
// Constants and types for the parallel flash pin behaviour block
package flash_pin_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W_MIN = 22;
    localparam int ADDR_W_MAX = 25;
    localparam int RCFG_W = 16;
    localparam int WAIT_POL_POS = 10;
    localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;

    typedef enum logic {
        MODE_ASYNC,
        MODE_SYNC
    } read_mode_t;
endpackage : flash_pin_pkg

/* File: flash_bus_pins.sv */
// Host-facing pin behaviour of a 16-bit parallel flash device
`timescale 1ns/1ps
`default_nettype none
module flash_bus_pins #(
    parameter int ADDR_W = flash_pin_pkg::ADDR_W_MAX,
    parameter bit DUAL_DIE = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    // Host control pins, sampled on clk
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic write_en_n,
    input wire logic address_valid_n,
    input wire logic reset_n,
    input wire logic write_protect_n,
    // Host address pins; die_sel is the bit above the word address
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic die_sel,
    // Data pins
    input wire logic [flash_pin_pkg::DATA_W-1:0] data_in,
    output logic [flash_pin_pkg::DATA_W-1:0] data_out,
    output logic data_oe_n,
    // Wait pin
    output logic wait_out,
    output logic wait_oe_n,
    // Supply monitors, high while above lockout
    input wire logic vpp_ok,
    input wire logic vcc_ok,
    // Core side: read data and mode control
    input wire logic [flash_pin_pkg::DATA_W-1:0] rd_data,
    input wire logic rd_valid,
    input wire logic [flash_pin_pkg::RCFG_W-1:0] read_config_register,
    input wire logic set_sync,
    input wire logic set_async,
    output logic sync_mode,
    // Core side: latched read address
    output logic [ADDR_W-1:0] latched_addr,
    output logic top_die,
    // Core side: captured write
    output logic wr_valid,
    output logic [ADDR_W-1:0] wr_addr,
    output logic [flash_pin_pkg::DATA_W-1:0] wr_data,
    output logic wr_top_die,
    // Core side: protection and automation
    input wire logic unlock_req,
    input wire logic block_locked_down,
    output logic unlock_grant,
    input wire logic alter_req,
    output logic alter_grant,
    output logic alter_refused,
    output logic automation_reset,
    output logic selected
);
    // Widths outside the supported densities cannot be served
    if (ADDR_W < flash_pin_pkg::ADDR_W_MIN || ADDR_W > flash_pin_pkg::ADDR_W_MAX) begin : g_bad_addr_w
        $error("ADDR_W out of range");
    end
    // Only the widest density comes as two stacked dies
    if (DUAL_DIE && ADDR_W != flash_pin_pkg::ADDR_W_MAX) begin : g_bad_dual_die
        $error("DUAL_DIE needs the widest address");
    end

    flash_pin_pkg::read_mode_t mode, next_mode;
    logic we_prev, next_we_prev;
    logic adv_held, next_adv_held;
    logic [ADDR_W-1:0] next_latched_addr, next_wr_addr;
    logic next_top_die, next_wr_top_die, next_wr_valid;
    logic [flash_pin_pkg::DATA_W-1:0] next_data_out, next_wr_data;
    logic next_data_oe_n, next_wait_out, next_wait_oe_n;
    logic next_unlock_grant, next_alter_grant, next_alter_refused;
    logic reading, wait_pol, wait_active, die_bit;

    always_comb begin
        reading = !chip_sel_n && !out_en_n && reset_n && write_en_n;
        wait_pol = read_config_register[flash_pin_pkg::WAIT_POL_POS];
        die_bit = DUAL_DIE ? die_sel : 1'b0;
        // Mode: reset forces asynchronous read-array
        next_mode = mode;
        if (!reset_n) begin
            next_mode = flash_pin_pkg::MODE_ASYNC;
        end else if (set_sync) begin
            next_mode = flash_pin_pkg::MODE_SYNC;
        end else if (set_async) begin
            next_mode = flash_pin_pkg::MODE_ASYNC;
        end
        // Address latch
        next_latched_addr = latched_addr;
        next_top_die = top_die;
        next_adv_held = adv_held;
        if (address_valid_n) begin
            next_adv_held = 1'b0;
        end else if (mode == flash_pin_pkg::MODE_SYNC) begin
            if (!adv_held) begin
                next_latched_addr = addr_in;
                next_top_die = die_bit;
                next_adv_held = 1'b1;
            end
        end else begin
            // Flow through while address valid is low, hold once it rises
            next_latched_addr = addr_in;
            next_top_die = die_bit;
        end
        // Write capture on strobe rise
        next_we_prev = write_en_n;
        next_wr_valid = 1'b0;
        next_wr_addr = wr_addr;
        next_wr_data = wr_data;
        next_wr_top_die = wr_top_die;
        if (write_en_n && !we_prev && !chip_sel_n && reset_n) begin
            next_wr_valid = 1'b1;
            next_wr_addr = addr_in;
            next_wr_data = data_in;
            next_wr_top_die = die_bit;
        end
        // Data bus
        next_data_oe_n = !reading;
        next_data_out = reading ? rd_data : flash_pin_pkg::DATA_RESET;
        // Wait pin: asserted only for invalid data in synchronous reads
        wait_active = reading && (mode == flash_pin_pkg::MODE_SYNC) && !rd_valid;
        next_wait_out = wait_active ? wait_pol : !wait_pol;
        next_wait_oe_n = chip_sel_n || out_en_n;
        // Protection decisions
        next_unlock_grant = unlock_req && reset_n && (write_protect_n || !block_locked_down);
        next_alter_grant = alter_req && reset_n && vpp_ok && vcc_ok;
        next_alter_refused = alter_req && !(reset_n && vpp_ok && vcc_ok);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode <= flash_pin_pkg::MODE_ASYNC;
            we_prev <= 1'b1;
            adv_held <= 1'b0;
            latched_addr <= '0;
            top_die <= 1'b0;
            wr_valid <= 1'b0;
            wr_addr <= '0;
            wr_data <= flash_pin_pkg::DATA_RESET;
            wr_top_die <= 1'b0;
            data_out <= flash_pin_pkg::DATA_RESET;
            data_oe_n <= 1'b1;
            wait_out <= 1'b0;
            wait_oe_n <= 1'b1;
            unlock_grant <= 1'b0;
            alter_grant <= 1'b0;
            alter_refused <= 1'b0;
            automation_reset <= 1'b1;
            selected <= 1'b0;
            sync_mode <= 1'b0;
        end else begin
            mode <= next_mode;
            we_prev <= next_we_prev;
            adv_held <= next_adv_held;
            latched_addr <= next_latched_addr;
            top_die <= next_top_die;
            wr_valid <= next_wr_valid;
            wr_addr <= next_wr_addr;
            wr_data <= next_wr_data;
            wr_top_die <= next_wr_top_die;
            data_out <= next_data_out;
            data_oe_n <= next_data_oe_n;
            wait_out <= next_wait_out;
            wait_oe_n <= next_wait_oe_n;
            unlock_grant <= next_unlock_grant;
            alter_grant <= next_alter_grant;
            alter_refused <= next_alter_refused;
            automation_reset <= !reset_n;
            selected <= !chip_sel_n;
            sync_mode <= (next_mode == flash_pin_pkg::MODE_SYNC);
        end
    end

    // Pin checks run on the sampling clock and are off while rst is high
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_float_when_off: assert property ((chip_sel_n || out_en_n) |=> (data_oe_n && wait_oe_n))
        else $error("bus not floated when deselected");
    a_drive_on_read: assert property ((!chip_sel_n && !out_en_n && reset_n && write_en_n)
        |=> (!data_oe_n && data_out == $past(rd_data)))
        else $error("data not driven during read");
    a_data_idle_zero: assert property (!(!chip_sel_n && !out_en_n && reset_n && write_en_n)
        |=> data_out == flash_pin_pkg::DATA_RESET)
        else $error("data pins not idle when not reading");
    a_select_track: assert property (1'b1 |=> selected == !$past(chip_sel_n))
        else $error("select flag does not follow chip select");
    a_reset_no_grant: assert property (!reset_n |=> (!unlock_grant && !alter_grant))
        else $error("grant issued under reset");
    a_reset_no_write: assert property (!reset_n |=> (!wr_valid && automation_reset))
        else $error("write taken under reset");
    a_reset_async_mode: assert property ((!reset_n ##1 reset_n) |-> !sync_mode)
        else $error("mode not async after reset");
    a_wait_invalid: assert property ((!chip_sel_n && !out_en_n && reset_n && write_en_n && sync_mode
        && !rd_valid && !set_async) |=> wait_out == $past(read_config_register[flash_pin_pkg::WAIT_POL_POS]))
        else $error("wait not asserted for invalid data");
    a_wait_async_off: assert property ((!sync_mode && !set_sync && reset_n)
        |=> wait_out != $past(read_config_register[flash_pin_pkg::WAIT_POL_POS]))
        else $error("wait asserted outside sync read");
    a_write_capture: assert property (($rose(write_en_n) && !chip_sel_n && reset_n)
        |=> (wr_valid && wr_data == $past(data_in) && wr_addr == $past(addr_in)))
        else $error("write not captured at strobe rise");
    a_die_route: assert property (($rose(write_en_n) && !chip_sel_n && reset_n)
        |=> wr_top_die == (DUAL_DIE && $past(die_sel)))
        else $error("write not routed to selected die");
    a_unlock_free: assert property ((unlock_req && !block_locked_down && reset_n) |=> unlock_grant)
        else $error("unlock of free block refused");
    a_lockdown_hold: assert property ((unlock_req && block_locked_down && !write_protect_n) |=> !unlock_grant)
        else $error("locked-down block unlocked");
    a_lockdown_over: assert property ((unlock_req && write_protect_n && reset_n) |=> unlock_grant)
        else $error("write protect high did not override");
    a_vpp_lockout: assert property ((alter_req && !vpp_ok) |=> (!alter_grant && alter_refused))
        else $error("alter granted at low program supply");
    a_vcc_lockout: assert property ((alter_req && !vcc_ok) |=> (!alter_grant && alter_refused))
        else $error("alter granted at low core supply");
    a_sync_latch: assert property ((sync_mode && !set_async && $fell(address_valid_n) && reset_n)
        |=> (latched_addr == $past(addr_in)) ##1 (address_valid_n || latched_addr == $past(latched_addr)))
        else $error("sync address latch wrong");
    a_async_flow: assert property ((!sync_mode && !address_valid_n)
        |=> (latched_addr == $past(addr_in) && top_die == (DUAL_DIE && $past(die_sel))))
        else $error("async address did not flow through");
    a_addr_hold: assert property (address_valid_n |=> latched_addr == $past(latched_addr))
        else $error("address changed with address valid high");

    c_sync_read: cover property (sync_mode && wait_active ##[1:8] !wait_active && !wait_oe_n);
    c_write: cover property (wr_valid && wr_top_die);
    c_refused: cover property (alter_refused);
    c_unlock: cover property (unlock_grant && block_locked_down);
    c_sync_latch: cover property (sync_mode && $fell(address_valid_n));
endmodule : flash_bus_pins
`default_nettype wire

/* File: host_model.sv */
// Host-side bus model that drives the flash chip select, output enable, write enable, address and write data pins
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Clock
    input wire logic clk,
    // Control pins
    output logic chip_sel_n,
    output logic out_en_n,
    output logic write_en_n,
    // Address and data pins
    output logic [flash_pin_pkg::ADDR_W_MAX-1:0] addr_in,
    output logic die_sel,
    output logic [flash_pin_pkg::DATA_W-1:0] data_in
);
    initial begin
        chip_sel_n = 1'b1;
        out_en_n = 1'b1;
        write_en_n = 1'b1;
        addr_in = 25'h0000000;
        die_sel = 1'b0;
        data_in = 16'h0000;
    end
    task automatic pins(input logic cs, input logic oe);
        @(posedge clk);
        chip_sel_n <= cs;
        out_en_n <= oe;
    endtask : pins
    task automatic addr(input logic [24:0] a, input logic top);
        @(posedge clk);
        addr_in <= a;
        die_sel <= top;
    endtask : addr
    // Output enable stays high while writing so the data pins never fight
    task automatic wr(input logic [24:0] a, input logic top, input logic [15:0] d);
        @(posedge clk);
        chip_sel_n <= 1'b0;
        out_en_n <= 1'b1;
        write_en_n <= 1'b0;
        addr_in <= a;
        die_sel <= top;
        data_in <= d;
        @(posedge clk);
        write_en_n <= 1'b1;
        @(posedge clk);
        chip_sel_n <= 1'b1;
        data_in <= ~d;
    endtask : wr
endmodule : host_model
`default_nettype wire

/* File: tb.sv */
// Self-checking testbench for the flash bus pin block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, rst, reset_n, write_protect_n, vpp_ok, vcc_ok, rd_valid, set_sync, set_async, address_valid_n;
    logic unlock_req, block_locked_down, alter_req, chip_sel_n, out_en_n, write_en_n, die_sel;
    logic [24:0] addr_in, latched_addr, wr_addr;
    logic [15:0] data_in, rd_data, read_config_register, data_out, wr_data;
    logic data_oe_n, wait_out, wait_oe_n, sync_mode, top_die, wr_valid, wr_top_die;
    logic unlock_grant, alter_grant, alter_refused, automation_reset, selected;
    int error_cnt, cmp_count, cyc;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    host_model u_host (.clk, .chip_sel_n, .out_en_n, .write_en_n, .addr_in, .die_sel, .data_in);
    flash_bus_pins #(.ADDR_W(25), .DUAL_DIE(1'b1)) u_dut (.clk, .rst, .chip_sel_n, .out_en_n,
        .write_en_n, .address_valid_n, .reset_n, .write_protect_n, .addr_in, .die_sel, .data_in,
        .data_out, .data_oe_n, .wait_out, .wait_oe_n, .vpp_ok, .vcc_ok, .rd_data, .rd_valid,
        .read_config_register, .set_sync, .set_async, .sync_mode, .latched_addr, .top_die, .wr_valid,
        .wr_addr, .wr_data, .wr_top_die, .unlock_req, .block_locked_down, .unlock_grant, .alter_req,
        .alter_grant, .alter_refused, .automation_reset, .selected);
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    // Looks for a capture pulse over a bounded window
    task automatic wait_wr(input logic exp);
        logic seen;
        seen = 1'b0;
        // The pulse stands only one cycle, so look before each edge
        repeat (4) begin
            #1;
            if (wr_valid === 1'b1) seen = 1'b1;
            @(posedge clk);
        end
        #1;
        check("wr_valid", seen, exp);
    endtask : wait_wr
    task automatic t_bus;
        u_host.pins(1'b0, 1'b0);
        settle(2);
        check("data_oe_n", data_oe_n, 0);
        check("data_out", data_out, 16'h5a3c);
        check("wait_oe_n", wait_oe_n, 1'h0);
        u_host.pins(1'b0, 1'b1);
        settle(2);
        check("data_oe_n", data_oe_n, 1);
        check("data_out", data_out, 16'h0000);
        check("wait_oe_n", wait_oe_n, 1);
        u_host.pins(1'b1, 1'b0);
        settle(2);
        check("data_oe_n", data_oe_n, 1);
        check("wait_oe_n", wait_oe_n, 1);
    endtask : t_bus
    task automatic t_write;
        u_host.wr(25'h1ffffff, 1'b1, 16'hc3a5);
        wait_wr(1'b1);
        check("wr_addr", wr_addr, 25'h1ffffff);
        check("wr_data", wr_data, 16'hc3a5);
        check("wr_top_die", wr_top_die, 1);
        @(posedge clk) reset_n <= 1'b0;
        u_host.wr(25'h0000001, 1'b0, 16'h0f0f);
        wait_wr(1'b0);
        check("automation_reset", automation_reset, 1);
        @(posedge clk) reset_n <= 1'b1;
    endtask : t_write
    task automatic t_wait;
        @(posedge clk) set_sync <= 1'b1;
        @(posedge clk) set_sync <= 1'b0;
        u_host.pins(1'b0, 1'b0);
        settle(2);
        check("wait_out", wait_out, 1);
        @(posedge clk) rd_valid <= 1'b1;
        settle(2);
        check("wait_out", wait_out, 0);
        @(posedge clk) read_config_register <= 16'h0000;
        rd_valid <= 1'b0;
        settle(2);
        check("wait_out", wait_out, 0);
        @(posedge clk) reset_n <= 1'b0;
        @(posedge clk) reset_n <= 1'b1;
        settle(2);
        check("sync_mode", sync_mode, 0);
        check("wait_out", wait_out, 1);
        u_host.pins(1'b1, 1'b1);
    endtask : t_wait
    task automatic t_addr;
        u_host.addr(25'h0abcdef, 1'b1);
        settle(2);
        check("latched_addr", latched_addr, 25'h0abcdef);
        check("top_die", top_die, 1'h1);
        @(posedge clk) address_valid_n <= 1'b1;
        u_host.addr(25'h1555555, 1'b0);
        settle(2);
        check("latched_addr", latched_addr, 25'h0abcdef);
        @(posedge clk) set_sync <= 1'b1;
        @(posedge clk) set_sync <= 1'b0;
        @(posedge clk) address_valid_n <= 1'b0;
        u_host.addr(25'h0123456, 1'b1);
        settle(2);
        check("latched_addr", latched_addr, 25'h1555555);
        check("top_die", top_die, 1'h0);
        @(posedge clk) set_async <= 1'b1;
        @(posedge clk) set_async <= 1'b0;
        settle(2);
        check("sync_mode", sync_mode, 1'h0);
        check("latched_addr", latched_addr, 25'h0123456);
        check("top_die", top_die, 1'h1);
        check("selected", selected, 1'h0);
        u_host.pins(1'b0, 1'b1);
        settle(2);
        check("selected", selected, 1'h1);
        u_host.pins(1'b1, 1'b1);
    endtask : t_addr
    task automatic req(input logic u, input logic a);
        @(posedge clk);
        unlock_req <= u;
        alter_req <= a;
        @(posedge clk);
        unlock_req <= 1'b0;
        alter_req <= 1'b0;
        #1;
    endtask : req
    task automatic t_protect;
        req(1'b1, 1'b0);
        check("unlock_grant", unlock_grant, 0);
        @(posedge clk) block_locked_down <= 1'b0;
        req(1'b1, 1'b0);
        check("unlock_grant", unlock_grant, 1'h1);
        @(posedge clk) write_protect_n <= 1'b1;
        block_locked_down <= 1'b1;
        req(1'b1, 1'b0);
        check("unlock_grant", unlock_grant, 1);
        @(posedge clk) vpp_ok <= 1'b0;
        req(1'b0, 1'b1);
        check("alter_refused", alter_refused, 1);
        @(posedge clk) vpp_ok <= 1'b1;
        vcc_ok <= 1'b0;
        req(1'b0, 1'b1);
        check("alter_grant", alter_grant, 0);
        check("alter_refused", alter_refused, 1'h1);
        @(posedge clk) vcc_ok <= 1'b1;
        req(1'b0, 1'b1);
        check("alter_grant", alter_grant, 1);
    endtask : t_protect
    always @(posedge clk) begin
        cyc++;
        if (cyc > 2000) begin
            error_cnt++;
            finish_test();
        end
    end
    initial begin
        {rst, reset_n, vpp_ok, vcc_ok, block_locked_down} = 5'h1f;
        {write_protect_n, rd_valid, set_sync, set_async, address_valid_n, unlock_req, alter_req} = 7'h00;
        rd_data = 16'h5a3c;
        read_config_register = 16'h0400;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_bus();
        t_write();
        t_wait();
        t_addr();
        t_protect();
        finish_test();
    end
endmodule : tb
`default_nettype wire
